// *** rtl/uirm_params.svh ***
// Purpose: Register offsets, field positions, reset values and timing constants.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Included by the UART module and the bench top module.
`ifndef UIRM_PARAMS_SVH
`define UIRM_PARAMS_SVH
`define UIRM_OFF_LINE_CTRL 12'h000
`define UIRM_OFF_DIVISOR 12'h004
`define UIRM_OFF_SYS_CTRL 12'h008
`define UIRM_OFF_TX_BUF 12'h00C
`define UIRM_OFF_RX_BUF 12'h010
`define UIRM_OFF_STATUS 12'h014
`define UIRM_OFF_IRQ_EN 12'h018
`define UIRM_OFF_IRQ_CLR 12'h01C
`define UIRM_LCR_RESET 8'h00
`define UIRM_SYS_RESET 8'h00
`define UIRM_DIV_RESET 16'h0000
`define UIRM_SYS_STOP_BIT 7
`define UIRM_OVERSAMPLE 5'd16
`define UIRM_OVS_LAST 4'hF
`define UIRM_OVS_MID 4'h7
`define UIRM_IR_PULSE 4'h3
`define UIRM_ST_TX_EMPTY 0
`define UIRM_ST_RX_READY 1
`define UIRM_ST_PARITY 2
`define UIRM_ST_FRAME 3
`define UIRM_ST_OVERRUN 4
`define UIRM_ST_WIDTH 5
`endif

// *** rtl/uirm_pkg.sv ***
// Purpose: Types shared by the serial transceiver.
// Assumes: Nothing beyond the params header.
// Notes: Line control layout follows the register bit order.
package uirm_pkg;
    typedef struct packed {
        logic ir_mode;
        logic reserved;
        logic [2:0] parity_mode;
        logic two_stop;
        logic [1:0] word_len;
    } uirm_lcr_t;

    typedef enum logic [2:0] {
        UIRM_IDLE = 3'b000,
        UIRM_START = 3'b001,
        UIRM_DATA = 3'b011,
        UIRM_PARITY = 3'b010,
        UIRM_STOP = 3'b110
    } uirm_state_t;
endpackage : uirm_pkg

// *** rtl/uirm_uart.sv ***
// Purpose: Single-channel UART with infrared pulse shaping and APB registers.
// Assumes: ext_clk_in is an external_clock_input level synchronous to pclk.
// Notes: Each bit lasts sixteen ticks; a tick is one divided external clock edge.
//
// Chosen here: the register addresses and the APB interface to the registers.
`include "uirm_params.svh"

// Summary of operation
// [RULE_01] Bit rate is the external clock divided by a software divisor.
// [RULE_02] Transmitter and receiver run independently and at the same time.
// [RULE_03] A frame ends with one or two stop bits as configured.
// [RULE_04] Data field is five to eight bits for both directions.
// [RULE_05] Parity is generated on transmit and checked on receive when enabled.
// [RULE_06] Transmit buffer moves into a shift register then shifts out on tx.
// [RULE_07] Receive shift register fills and each character moves into receive buffer.
// [RULE_08] Status is readable and events raise an interrupt.
// [RULE_09] Block runs while the stop bit of system control is zero.
// [RULE_10] Infrared signalling is chosen by the line control infrared bit.
// [RULE_11] Normal mode holds each bit level for the whole bit period.
// [RULE_12] Infrared one is a high pulse of three sixteenths; zero stays low.
// [RULE_13] Infrared receive reads a short high pulse within a bit as one.
// [RULE_14] Line control stop bit zero gives one stop bit, one gives two.
// [RULE_15] Top line control bit selects normal when zero, infrared when one.
// [RULE_16] Frame is low start bit, data LSB first, parity, then stop bits.
module uirm_uart
    import uirm_pkg::*;
(
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link.
    input wire logic ext_clk_in,
    input wire logic rx_in,
    output logic tx_out,
    // Interrupt.
    output logic irq
);
    uirm_lcr_t lcr_ff, nxt_lcr;
    logic [15:0] div_ff, nxt_div;
    logic [7:0] sys_ff, nxt_sys;
    logic [7:0] txbuf_ff, nxt_txbuf;
    logic txfull_ff, nxt_txfull;
    logic [7:0] rxbuf_ff;
    logic [`UIRM_ST_WIDTH-1:0] st_ff, ien_ff, nxt_ien;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, irq_ff;
    logic ext_d_ff, nxt_ext_d;
    logic [15:0] dcnt_ff, nxt_dcnt;
    logic tick_ff, nxt_tick;
    uirm_state_t ts_ff, nxt_ts, rs_ff, nxt_rs;
    logic [3:0] tov_ff, nxt_tov, rov_ff, nxt_rov;
    logic [2:0] tbit_ff, nxt_tbit, rbit_ff, nxt_rbit;
    logic [7:0] tsh_ff, nxt_tsh, rsh_ff;
    logic tstop2_ff, nxt_tstop2, tpar_ff, nxt_tpar, tx_ff, nxt_tx;
    logic rx_d_ff, nxt_rx_d, rhigh_ff, nxt_rhigh;
    logic run, wr, rd, acc, tx_lvl, rx_bit, parbit;
    logic [`UIRM_ST_WIDTH-1:0] ev;

    // Parity over the active data bits; modes 4..7 per table, else none.
    function automatic logic par_calc(input logic [7:0] d, input logic [1:0] wl,
                                      input logic [2:0] pm);
        logic [7:0] m;
        logic p;
        m = 8'hFF >> (2'd3 - wl);
        p = ^(d & m);
        case (pm)
            3'b100: par_calc = ~p;
            3'b101: par_calc = p;
            3'b110: par_calc = 1'b1;
            3'b111: par_calc = 1'b0;
            default: par_calc = 1'b0;
        endcase
    endfunction : par_calc

    assign run = ~sys_ff[`UIRM_SYS_STOP_BIT]; // [RULE_09]
    assign acc = psel & penable & ~pready_ff;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    always_comb begin
        nxt_lcr = lcr_ff;
        nxt_div = div_ff;
        nxt_sys = sys_ff;
        nxt_ien = ien_ff;
        nxt_pready = acc;
        nxt_pslverr = 1'b0;
        nxt_prdata = 32'h0000_0000;
        if (acc) begin
            case (paddr)
                `UIRM_OFF_LINE_CTRL: nxt_prdata = {24'h00_0000, lcr_ff};
                `UIRM_OFF_DIVISOR: nxt_prdata = {16'h0000, div_ff};
                `UIRM_OFF_SYS_CTRL: nxt_prdata = {24'h00_0000, sys_ff};
                `UIRM_OFF_TX_BUF: nxt_prdata = {24'h00_0000, txbuf_ff};
                `UIRM_OFF_RX_BUF: nxt_prdata = {24'h00_0000, rxbuf_ff};
                `UIRM_OFF_STATUS: nxt_prdata = {27'h000_0000, st_ff};
                `UIRM_OFF_IRQ_EN: nxt_prdata = {27'h000_0000, ien_ff};
                `UIRM_OFF_IRQ_CLR: nxt_prdata = 32'h0000_0000;
                default: nxt_pslverr = 1'b1;
            endcase
            if (pwrite) begin
                nxt_prdata = 32'h0000_0000;
                case (paddr)
                    `UIRM_OFF_LINE_CTRL: nxt_lcr = uirm_lcr_t'(pwdata[7:0]); // [RULE_10] [RULE_15]
                    `UIRM_OFF_DIVISOR: nxt_div = pwdata[15:0]; // [RULE_01]
                    `UIRM_OFF_SYS_CTRL: nxt_sys = pwdata[7:0];
                    `UIRM_OFF_IRQ_EN: nxt_ien = pwdata[`UIRM_ST_WIDTH-1:0];
                    default: nxt_ien = ien_ff;
                endcase
            end
        end
    end

    // Baud tick: one tick per (divisor+1) rising edges of the external clock.
    always_comb begin
        nxt_ext_d = ext_clk_in;
        nxt_dcnt = dcnt_ff;
        nxt_tick = 1'b0;
        if (!run) begin
            nxt_dcnt = `UIRM_DIV_RESET;
        end else if (ext_clk_in & ~ext_d_ff) begin
            if (dcnt_ff >= div_ff) begin
                nxt_dcnt = `UIRM_DIV_RESET;
                nxt_tick = 1'b1; // [RULE_01]
            end else begin
                nxt_dcnt = dcnt_ff + 16'h0001;
            end
        end
    end

    // Transmitter.
    always_comb begin
        nxt_ts = ts_ff;
        nxt_tov = tov_ff;
        nxt_tbit = tbit_ff;
        nxt_tsh = tsh_ff;
        nxt_tstop2 = tstop2_ff;
        nxt_tpar = tpar_ff;
        nxt_txbuf = txbuf_ff;
        nxt_txfull = txfull_ff;
        ev = '0;
        if (wr && paddr == `UIRM_OFF_TX_BUF) begin
            nxt_txbuf = pwdata[7:0];
            nxt_txfull = 1'b1;
        end
        case (ts_ff)
            UIRM_START: tx_lvl = 1'b0; // [RULE_16]
            UIRM_DATA: tx_lvl = tsh_ff[0];
            UIRM_PARITY: tx_lvl = tpar_ff; // [RULE_05]
            default: tx_lvl = 1'b1;
        endcase
        if (run && ts_ff == UIRM_IDLE && txfull_ff) begin
            nxt_tsh = txbuf_ff; // [RULE_06]
            nxt_ts = UIRM_START;
            nxt_tov = 4'h0;
            nxt_tbit = 3'd0;
            nxt_tstop2 = lcr_ff.two_stop; // [RULE_14]
            // Parity is fixed at load, so a new character in the buffer cannot corrupt it.
            nxt_tpar = par_calc(txbuf_ff, lcr_ff.word_len, lcr_ff.parity_mode); // [RULE_05]
            ev[`UIRM_ST_TX_EMPTY] = 1'b1;
            nxt_txfull = wr && paddr == `UIRM_OFF_TX_BUF;
        end else if (run && tick_ff && ts_ff != UIRM_IDLE) begin
            nxt_tov = tov_ff + 4'h1;
            if (tov_ff == `UIRM_OVS_LAST) begin
                case (ts_ff)
                    UIRM_START: nxt_ts = UIRM_DATA;
                    UIRM_DATA: begin
                        nxt_tsh = {1'b0, tsh_ff[7:1]}; // [RULE_16]
                        nxt_tbit = tbit_ff + 3'd1;
                        if (tbit_ff == {1'b1, lcr_ff.word_len}) begin // [RULE_04]
                            nxt_ts = lcr_ff.parity_mode[2] ? UIRM_PARITY : UIRM_STOP; // [RULE_05]
                        end
                    end
                    UIRM_PARITY: nxt_ts = UIRM_STOP;
                    UIRM_STOP: begin
                        nxt_tstop2 = 1'b0;
                        nxt_ts = tstop2_ff ? UIRM_STOP : UIRM_IDLE; // [RULE_03]
                    end
                    default: nxt_ts = UIRM_IDLE;
                endcase
            end
        end
        // Infrared shapes a one as a pulse in the first 3/16 of the bit, a zero stays low.
        if (lcr_ff.ir_mode) begin
            nxt_tx = tx_lvl & (tov_ff < `UIRM_IR_PULSE) & (ts_ff != UIRM_IDLE); // [RULE_12]
        end else begin
            nxt_tx = tx_lvl; // [RULE_11]
        end
        if (!run) begin
            nxt_ts = UIRM_IDLE;
            nxt_tx = ~lcr_ff.ir_mode;
        end
    end

    // Receiver: mid-bit sampling in normal mode, end-of-bit in infrared; there the start bit has no pulse, so the first pulse starts.
    always_comb begin
        nxt_rx_d = rx_in;
        nxt_rs = rs_ff;
        nxt_rov = rov_ff;
        nxt_rbit = rbit_ff;
        nxt_rhigh = rhigh_ff;
        // In infrared mode a pulse seen anywhere in the bit reads as a one.
        rx_bit = lcr_ff.ir_mode ? (rhigh_ff | rx_d_ff) : rx_d_ff; // [RULE_13]
        if (!run) begin
            nxt_rs = UIRM_IDLE;
        end else if (rs_ff == UIRM_IDLE) begin
            if (lcr_ff.ir_mode ? rx_d_ff : ~rx_d_ff) begin
                nxt_rs = UIRM_START;
                nxt_rov = 4'h0;
                nxt_rhigh = 1'b0;
            end
        end else if (tick_ff) begin
            nxt_rov = rov_ff + 4'h1;
            if (lcr_ff.ir_mode && rx_d_ff) begin
                nxt_rhigh = 1'b1; // [RULE_13]
            end
            if (rov_ff == `UIRM_OVS_LAST) begin
                nxt_rhigh = 1'b0;
                case (rs_ff)
                    UIRM_START: begin
                        nxt_rs = UIRM_DATA;
                        nxt_rbit = 3'd0;
                    end
                    UIRM_DATA: begin
                        nxt_rbit = rbit_ff + 3'd1;
                        if (rbit_ff == {1'b1, lcr_ff.word_len}) begin // [RULE_04]
                            nxt_rs = lcr_ff.parity_mode[2] ? UIRM_PARITY : UIRM_STOP;
                        end
                    end
                    UIRM_PARITY: nxt_rs = UIRM_STOP;
                    UIRM_STOP: nxt_rs = UIRM_IDLE;
                    default: nxt_rs = UIRM_IDLE;
                endcase
            end
        end
    end

    // Sampling point events for the receiver, kept apart for readability.
    logic samp, lsb_align;
    logic [7:0] rsh_j;
    logic [`UIRM_ST_WIDTH-1:0] rev;
    always_comb begin
        samp = run && tick_ff && (rs_ff != UIRM_IDLE) &&
               (lcr_ff.ir_mode ? rov_ff == `UIRM_OVS_LAST : rov_ff == `UIRM_OVS_MID);
        rev = '0;
        lsb_align = samp && rs_ff == UIRM_DATA;
        rsh_j = rsh_ff >> (2'd3 - lcr_ff.word_len);
        parbit = par_calc(rsh_j, lcr_ff.word_len, lcr_ff.parity_mode);
        if (samp && rs_ff == UIRM_PARITY && rx_bit != parbit) begin
            rev[`UIRM_ST_PARITY] = 1'b1; // [RULE_05]
        end
        if (samp && rs_ff == UIRM_STOP) begin
            rev[`UIRM_ST_RX_READY] = 1'b1; // [RULE_07]
            rev[`UIRM_ST_FRAME] = ~rx_bit;
            rev[`UIRM_ST_OVERRUN] = st_ff[`UIRM_ST_RX_READY];
        end
    end
    // Status: hardware set wins over a software clear in the same cycle.
    logic [`UIRM_ST_WIDTH-1:0] clr, evall, stn;
    always_comb begin
        clr = (wr && paddr == `UIRM_OFF_IRQ_CLR) ? pwdata[`UIRM_ST_WIDTH-1:0] : '0;
        if (rd && paddr == `UIRM_OFF_RX_BUF) begin
            clr[`UIRM_ST_RX_READY] = 1'b1;
        end
        evall = ev | rev;
        stn = (st_ff & ~clr) | evall;
        stn[`UIRM_ST_TX_EMPTY] = stn[`UIRM_ST_TX_EMPTY] | (~txfull_ff & (ts_ff == UIRM_IDLE));
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lcr_ff <= uirm_lcr_t'(`UIRM_LCR_RESET);
            div_ff <= `UIRM_DIV_RESET;
            sys_ff <= `UIRM_SYS_RESET;
            ien_ff <= '0;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            ext_d_ff <= 1'b0;
            dcnt_ff <= `UIRM_DIV_RESET;
            tick_ff <= 1'b0;
            ts_ff <= UIRM_IDLE;
            tov_ff <= 4'h0;
            tbit_ff <= 3'd0;
            tsh_ff <= 8'h00;
            tstop2_ff <= 1'b0;
            tpar_ff <= 1'b0;
            txbuf_ff <= 8'h00;
            txfull_ff <= 1'b0;
            tx_ff <= 1'b1;
            rx_d_ff <= 1'b1;
            rs_ff <= UIRM_IDLE;
            rov_ff <= 4'h0;
            rbit_ff <= 3'd0;
            rsh_ff <= 8'h00;
            rxbuf_ff <= 8'h00;
            rhigh_ff <= 1'b0;
            st_ff <= 5'h01;
            irq_ff <= 1'b0;
        end else begin
            lcr_ff <= nxt_lcr;
            div_ff <= nxt_div;
            sys_ff <= nxt_sys;
            ien_ff <= nxt_ien;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            ext_d_ff <= nxt_ext_d;
            dcnt_ff <= nxt_dcnt;
            tick_ff <= nxt_tick;
            ts_ff <= nxt_ts;
            tov_ff <= nxt_tov;
            tbit_ff <= nxt_tbit;
            tsh_ff <= nxt_tsh;
            tstop2_ff <= nxt_tstop2;
            tpar_ff <= nxt_tpar;
            txbuf_ff <= nxt_txbuf;
            txfull_ff <= nxt_txfull;
            tx_ff <= nxt_tx;
            rx_d_ff <= nxt_rx_d;
            rs_ff <= nxt_rs;
            rov_ff <= nxt_rov;
            rbit_ff <= nxt_rbit;
            rhigh_ff <= nxt_rhigh;
            // Shift in at the top so the first bit ends at bit 0 for 8-bit words.
            rsh_ff <= lsb_align ? {rx_bit, rsh_ff[7:1]} : rsh_ff; // [RULE_16]
            rxbuf_ff <= rev[`UIRM_ST_RX_READY] ? rsh_j : rxbuf_ff; // [RULE_07]
            st_ff <= stn; // [RULE_08]
            irq_ff <= |(stn & ien_ff); // [RULE_08]
        end
    end
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign tx_out = tx_ff;
    assign irq = irq_ff;
endmodule : uirm_uart

// *** tb/uirm_uart_chk.sv ***
// Purpose: Port-level checks of bus answers and interrupt masking.
// Assumes: Bound to uirm_uart from the bench top file.
// Notes: One clock domain, so default clocking and disable are used.
module uirm_chk (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt.
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable && !pready;
    ready_wait_a:
        assert property (acc |=> pready) else $error("No ready after access.");
    ready_pulse_a:
        assert property (pready |=> !pready) else $error("Ready held too long.");
    ready_cause_a:
        assert property (pready |-> $past(psel) && $past(penable))
        else $error("Ready without access.");
    err_qual_a:
        assert property (pslverr |-> pready) else $error("Error without ready.");
    err_unmapped_a:
        assert property (acc && paddr > 12'h01C |=> pslverr)
        else $error("Unmapped access not refused.");
    err_mapped_a:
        assert property (acc && paddr <= 12'h01C && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("Mapped access refused.");
    err_read_zero_a:
        assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("Refused read not zero.");
    status_width_a:
        assert property (pready && !pwrite && paddr == 12'h014 |-> prdata[31:5] == 27'h000_0000)
        else $error("Status upper bits set.");
    irq_masked_a:
        assert property (pready && pwrite && paddr == 12'h018 && pwdata[4:0] == 5'h00
            |-> ##2 !irq) else $error("Interrupt with all sources masked.");
endmodule : uirm_chk

// *** tb/uirm_peer.sv ***
// Purpose: Remote serial transceiver facing the block's pins.
// Assumes: Bit time given in pclk cycles by the caller.
// Notes: Frames are passed LSB first as bit vectors.
module uirm_peer (
    // Clock.
    input wire logic pclk,
    // Serial lines.
    input wire logic tx_line,
    output logic rx_line
);
    initial rx_line = 1'b1;
    // The line returns to idle high after the last stop bit.
    task automatic send(input logic [11:0] f, input int n, input int bc);
        for (int i = 0; i < n; i++) begin
            rx_line <= f[i];
            repeat (bc) @(posedge pclk);
        end
        rx_line <= 1'b1;
    endtask : send
    // Samples mid-bit; returns all ones if no start bit shows within lim.
    task automatic recv(output logic [11:0] f, input int n, input int bc, input int lim);
        int k;
        f = 12'hFFF;
        k = 0;
        while (tx_line !== 1'b0 && k < lim) begin
            @(posedge pclk);
            k++;
        end
        if (k < lim) begin
            repeat (bc / 2) @(posedge pclk);
            for (int i = 0; i < n; i++) begin
                f[i] = tx_line;
                repeat (bc) @(posedge pclk);
            end
        end
    endtask : recv
endmodule : uirm_peer

// *** tb/uirm_uart_tb_top.sv ***
// Purpose: Self-checking bench for the serial transceiver.
// Assumes: Divisor 0 or 1; a bit is sixteen ticks of two (divisor 0) or four (divisor 1) pclk cycles each.
// Notes: The peer model plays the remote transceiver.
`include "uirm_params.svh"
module uirm_uart_tb_top
    import uirm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic ext_clk_in = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, tx_out, irq, rx_in;
    int err_total = 0;
    int check_count = 0;
    always #20 pclk = ~pclk;
    always @(posedge pclk) ext_clk_in <= ~ext_clk_in;
    uirm_uart u_uirm_uart (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clk_in(ext_clk_in), .rx_in(rx_in), .tx_out(tx_out), .irq(irq));
    uirm_peer peer (.pclk(pclk), .tx_line(tx_out), .rx_line(rx_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) chk(32'h0, 32'h1, "bus answer");
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask : wr
    function automatic logic [11:0] mk_frame(input logic [7:0] d, input uirm_lcr_t c,
        output int n);
        logic p;
        mk_frame = 12'hFFF;
        mk_frame[0] = 1'b0;
        n = 1;
        p = ^(d & (8'hFF >> (3 - c.word_len)));
        for (int i = 0; i < c.word_len + 5; i++) begin
            mk_frame[n] = d[i];
            n++;
        end
        if (c.parity_mode[2]) begin
            mk_frame[n] = c.parity_mode[1] ? ~c.parity_mode[0] : p ^ ~c.parity_mode[0];
            n++;
        end
        n += c.two_stop ? 2 : 1;
    endfunction : mk_frame
    task automatic final_report();
        $display("Mismatches %0d, comparisons %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #(60000 * 40);
        err_total++;
        final_report();
    end
    initial begin
        uirm_lcr_t c;
        logic [31:0] r;
        logic [11:0] got, fe;
        logic [7:0] dt, dr;
        int n, bc, dv, pulses, run, badw;
        void'($urandom(32'h2941));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `UIRM_OFF_STATUS, 32'h0, r);
        chk(r, 32'h0000_0001, "status reset");
        apb(1'b0, `UIRM_OFF_SYS_CTRL, 32'h0, r);
        chk(r, 32'h0, "sys reset");
        apb(1'b0, 12'h040, 32'h0, r);
        chk(r, 32'h0, "unmapped read");
        wr(`UIRM_OFF_IRQ_EN, 32'h0);
        for (int i = 0; i < 8; i++) begin
            c = '0;
            c.word_len = i[1:0];
            c.two_stop = i[2];
            c.parity_mode = {i != 7, (i < 4) ? i[1:0] : 2'($urandom)};
            dv = $urandom_range(1, 0);
            bc = 32 * (dv + 1);
            dt = 8'($urandom);
            dr = 8'($urandom);
            wr(`UIRM_OFF_DIVISOR, 32'(dv));
            wr(`UIRM_OFF_LINE_CTRL, {24'h00_0000, c});
            fe = mk_frame(dr, c, n);
            fork
                wr(`UIRM_OFF_TX_BUF, {24'h00_0000, dt});
                peer.send(fe, n, bc);
                peer.recv(got, n, bc, 4 * bc);
            join
            chk(32'(got), 32'(mk_frame(dt, c, n)), "tx frame");
            apb(1'b0, `UIRM_OFF_STATUS, 32'h0, r);
            chk(32'(r[4:1]), 32'h1, "rx status");
            apb(1'b0, `UIRM_OFF_RX_BUF, 32'h0, r);
            chk(r, 32'(dr & (8'hFF >> (3 - c.word_len))), "rx data");
            chk(32'(irq), 32'h0, "irq masked");
        end
        c.parity_mode = 3'b101;
        wr(`UIRM_OFF_DIVISOR, 32'h0);
        wr(`UIRM_OFF_LINE_CTRL, {24'h00_0000, c});
        wr(`UIRM_OFF_IRQ_EN, 32'h0000_0004);
        fe = mk_frame(8'h5A, c, n);
        fe[9] = ~fe[9];
        peer.send(fe, n, 32);
        repeat (4) @(posedge pclk);
        chk(32'(irq), 32'h1, "irq on parity");
        apb(1'b0, `UIRM_OFF_STATUS, 32'h0, r);
        chk(32'(r[2]), 32'h1, "parity flag");
        wr(`UIRM_OFF_IRQ_CLR, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0, "irq cleared");
        apb(1'b0, `UIRM_OFF_RX_BUF, 32'h0, r);
        wr(`UIRM_OFF_SYS_CTRL, 32'h0000_0080);
        fork
            wr(`UIRM_OFF_TX_BUF, 32'h0000_0033);
            peer.recv(got, n, 32, 800);
        join
        chk(32'(got), 32'h0000_0FFF, "stopped tx");
        wr(`UIRM_OFF_SYS_CTRL, 32'h0);
        repeat (800) @(posedge pclk);
        wr(`UIRM_OFF_LINE_CTRL, 32'h0000_0083);
        wr(`UIRM_OFF_TX_BUF, 32'h0000_00A7);
        pulses = 0;
        run = 0;
        badw = 0;
        // A one bit and the stop bit each give a pulse of three ticks.
        repeat (14 * 32) begin
            @(posedge pclk);
            if (tx_out === 1'b1) begin
                run++;
            end else begin
                if (run > 0) begin
                    pulses++;
                    badw += (run != 6);
                end
                run = 0;
            end
        end
        chk(32'(pulses), 32'h0000_0006, "ir pulses");
        chk(32'(badw), 32'h0, "ir width");
        final_report();
    end
endmodule : uirm_uart_tb_top
bind uirm_uart uirm_chk u_uirm_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
